// ---- logic/rmv_pkg.sv ----
// reset, mode and vector unit: shared constants, field layouts and carriers
// assumes a classic wishbone master, 32-bit data, one register per word
package rmv_pkg;
   // register indices; byte address is four times the index
   localparam logic [7:0] IDX_IDENT_HI = 8'h1A;
   localparam logic [7:0] IDX_IDENT_LO = 8'h1B;
   localparam logic [7:0] IDX_MODE = 8'h1C;
   localparam logic [7:0] IDX_CTRL = 8'h1D;
   localparam logic [7:0] IDX_VBASE = 8'h1F;
   localparam logic [7:0] IDX_VER = 8'h20;
   localparam logic [7:0] IDX_STAT = 8'h21;
   // identity fields, values arbitrary
   localparam logic [3:0] ID_MAJOR_FAM = 4'h6;
   localparam logic [5:0] ID_MINOR_FAM = 6'h15;
   localparam logic [1:0] ID_MAJOR_REV = 2'h1;
   localparam logic [3:0] ID_MINOR_REV = 4'h2;
   localparam int ID_MAJOR_FAM_LSB = 12;
   localparam int ID_MINOR_FAM_LSB = 6;
   localparam int ID_MAJOR_REV_LSB = 4;
   localparam logic [15:0] ID_VALUE =
      {ID_MAJOR_FAM, ID_MINOR_FAM, ID_MAJOR_REV, ID_MINOR_REV};
   localparam logic MODE_NORMAL = 1'b1;
   localparam logic MODE_SPECIAL = 1'b0;
   localparam logic [15:0] VEC_RESET = 16'hFFFE;
   localparam logic [15:0] VEC_CLKMON = 16'hFFFC;
   localparam logic [15:0] VEC_WDOG = 16'hFFFA;
   localparam logic [7:0] OFF_SPI = 8'hD8;
   localparam logic [7:0] OFF_LOCK = 8'hC6;
   localparam logic [7:0] OFF_LVI = 8'h8A;
   localparam logic [7:0] VBASE_RST = 8'hFF;
   // control register fields
   localparam int CTRL_OSCILLATOR_ENABLE = 0;
   localparam int CTRL_RATE_LSB = 1;
   localparam int CTRL_LOW_VOLTAGE_IRQ_ENABLE = 4;
   localparam int CTRL_PLL_LOCK_IRQ_ENABLE = 5;
   localparam int CTRL_SERIAL_RX_IRQ_ENABLE = 6;
   localparam int CTRL_SERIAL_TX_IRQ_ENABLE = 7;
   localparam logic [7:0] CTRL_RST = 8'h01;
   // status register fields
   localparam int STAT_CFG = 0;
   localparam int STAT_PROT = 1;
   localparam int STAT_DBG = 2;
   localparam int STAT_CAUSE_LSB = 16;
   typedef struct packed {
      logic por;
      logic low_voltage_reset;
      logic pin;
      logic illegal;
      logic clkmon;
      logic wdog;
   } rmv_rst_src_s;
   typedef struct packed {
      logic spi_rx;
      logic spi_tx;
      logic lock;
      logic low_voltage_interrupt;
   } rmv_irq_src_s;
   typedef struct packed {
      logic done;
      logic dbl_err;
      logic [2:0] opt;
      logic [15:0] version;
   } rmv_flash_cfg_s;
   typedef enum logic [1:0] {BOOT_RESET, BOOT_LOAD, BOOT_RUN} rmv_boot_e;
endpackage

// ---- logic/rmv_top.sv ----
// reset, mode and vector unit: wishbone registers, mode latch, reset cause
// and interrupt vector selection, flash configuration hold
// assumes reset sources, flash and interrupt requests run on clock_i
//
// Local design decision: the Wishbone register port.
`timescale 1ns/100ps
module rmv_top (
   input wire logic clock_i,
   input wire logic rst_b_i,
   input wire logic ce_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [9:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic wb_ack_o,
   output logic [31:0] wb_dat_o,
   input wire logic mode_select_pin_state_i,
   input wire rmv_pkg::rmv_rst_src_s rst_src_i,
   input wire rmv_pkg::rmv_flash_cfg_s flash_cfg_i,
   input wire logic flash_busy_i,
   input wire rmv_pkg::rmv_irq_src_s irq_src_i,
   input wire logic i_bit_i,
   input wire logic wait_i,
   output logic sys_rst_req_o,
   output logic [15:0] reset_vector_o,
   output logic cpu_hold_o,
   output logic flash_abort_o,
   output logic flash_protect_o,
   output logic debug_mode_o,
   output logic irq_req_o,
   output logic [15:0] irq_vector_o,
   output logic wake_o
);

   function automatic logic reg_hit(input logic [7:0] idx,
                                    input logic [7:0] want);
      reg_hit = (idx == want);
   endfunction

   function automatic logic [15:0] cause_vec(input logic fatal,
                                             input logic clk_fail);
      cause_vec = fatal ? rmv_pkg::VEC_RESET :
                  clk_fail ? rmv_pkg::VEC_CLKMON : rmv_pkg::VEC_WDOG;
   endfunction

   logic ack_ff, srst_ff, mode_ff, hold_ff, abort_ff, prot_ff, dbg_ff;
   logic irq_ff, wake_ff, sync1_ff, sync2_ff;
   logic [31:0] dat_ff;
   logic [15:0] cause_ff, ver_ff, ivec_ff;
   logic [7:0] ctrl_ff, vbase_ff;
   rmv_pkg::rmv_boot_e boot_ff, nxt_boot;

   // ram arrays live elsewhere and are deliberately untouched here

   // reset qualifiers: clr acts even with clock enable low for the pin reset
   wire in_rst = ~rst_b_i | srst_ff;
   wire clr = ~rst_b_i | (ce_i & srst_ff);
   wire running = (boot_ff == rmv_pkg::BOOT_RUN);

   // bus decode
   wire [7:0] idx = wb_adr_i[9:2];
   wire req = wb_cyc_i & wb_stb_i & ~ack_ff;
   wire wr_lo = req & wb_we_i & wb_sel_i[0];
   wire hit_idh = reg_hit(idx, rmv_pkg::IDX_IDENT_HI);
   wire hit_idl = reg_hit(idx, rmv_pkg::IDX_IDENT_LO);
   wire hit_mode = reg_hit(idx, rmv_pkg::IDX_MODE);
   wire hit_ctrl = reg_hit(idx, rmv_pkg::IDX_CTRL);
   wire hit_vbase = reg_hit(idx, rmv_pkg::IDX_VBASE);
   wire hit_ver = reg_hit(idx, rmv_pkg::IDX_VER);
   wire hit_stat = reg_hit(idx, rmv_pkg::IDX_STAT);

   // control fields
   wire osc_enable = ctrl_ff[rmv_pkg::CTRL_OSCILLATOR_ENABLE];
   wire [2:0] watchdog_rate_field = ctrl_ff[rmv_pkg::CTRL_RATE_LSB +: 3];
   wire low_voltage_irq_enable = ctrl_ff[rmv_pkg::CTRL_LOW_VOLTAGE_IRQ_ENABLE];
   wire pll_lock_irq_enable = ctrl_ff[rmv_pkg::CTRL_PLL_LOCK_IRQ_ENABLE];
   wire serial_rx_irq_enable = ctrl_ff[rmv_pkg::CTRL_SERIAL_RX_IRQ_ENABLE];
   wire serial_tx_irq_enable = ctrl_ff[rmv_pkg::CTRL_SERIAL_TX_IRQ_ENABLE];

   // read mux; identity is a constant so no write or reset can move it
   wire [31:0] stat_word = {cause_ff, 13'h0000, dbg_ff, prot_ff, ~hold_ff};
   wire [31:0] rd_data =
      hit_idh ? {24'h000000, rmv_pkg::ID_VALUE[15:8]} :
      hit_idl ? {24'h000000, rmv_pkg::ID_VALUE[7:0]} :
      hit_mode ? {31'h00000000, mode_ff} :
      hit_ctrl ? {24'h000000, ctrl_ff} :
      hit_vbase ? {24'h000000, vbase_ff} :
      hit_ver ? {16'h0000, ver_ff} :
      hit_stat ? stat_word : 32'h00000000;

   // reset sources; the fatal group has no mask and no enable
   wire fatal_src = rst_src_i.por | rst_src_i.low_voltage_reset | rst_src_i.pin |
                    rst_src_i.illegal;
   wire clk_src = rst_src_i.clkmon & osc_enable;
   wire wdog_src = rst_src_i.wdog & (watchdog_rate_field != 3'h0);
   wire nxt_srst = running & ~srst_ff & (fatal_src | clk_src | wdog_src);

   // interrupt enables and fixed priority, highest offset first
   wire en_spi = (irq_src_i.spi_rx & serial_rx_irq_enable) |
                 (irq_src_i.spi_tx & serial_tx_irq_enable);
   wire en_lock = irq_src_i.lock & pll_lock_irq_enable;
   wire en_lvi = irq_src_i.low_voltage_interrupt & low_voltage_irq_enable;
   wire [7:0] irq_off = en_spi ? rmv_pkg::OFF_SPI :
                        en_lock ? rmv_pkg::OFF_LOCK :
                        rmv_pkg::OFF_LVI;
   wire nxt_irq = running & ~i_bit_i & (en_spi | en_lock | en_lvi);
   wire nxt_wake = running & wait_i & ~i_bit_i & (en_spi | en_lvi);

   // boot sequence: reset, configuration load, run
   always_comb begin
      case (boot_ff)
         rmv_pkg::BOOT_RESET: nxt_boot = rmv_pkg::BOOT_LOAD;
         rmv_pkg::BOOT_LOAD: begin
            nxt_boot = flash_cfg_i.done ? rmv_pkg::BOOT_RUN :
                       rmv_pkg::BOOT_LOAD;
         end
         rmv_pkg::BOOT_RUN: nxt_boot = rmv_pkg::BOOT_RUN;
         default: nxt_boot = rmv_pkg::BOOT_RESET;
      endcase
   end
   wire load_done = (boot_ff == rmv_pkg::BOOT_LOAD) & flash_cfg_i.done;
   wire release_edge = (boot_ff == rmv_pkg::BOOT_RESET);

   // mode pin comes from outside: two flops before use, free of reset
   always_ff @(posedge clock_i) begin
      if (ce_i) begin
         sync1_ff <= mode_select_pin_state_i;
         sync2_ff <= sync1_ff;
      end
   end

   wire nxt_mode = release_edge ? sync2_ff :
                   (wr_lo & hit_mode & wb_dat_i[0]) ?
                   rmv_pkg::MODE_NORMAL : mode_ff;

   always_ff @(posedge clock_i) begin
      if (clr) begin
         boot_ff <= rmv_pkg::BOOT_RESET;
         mode_ff <= rmv_pkg::MODE_NORMAL;
         dbg_ff <= 1'b0;
         hold_ff <= 1'b1;
      end else if (ce_i) begin
         boot_ff <= nxt_boot;
         mode_ff <= nxt_mode;
         dbg_ff <= (nxt_mode == rmv_pkg::MODE_SPECIAL);
         hold_ff <= (nxt_boot != rmv_pkg::BOOT_RUN);
      end
   end

   // configuration loaded from flash: protection, version, watchdog rate
   always_ff @(posedge clock_i) begin
      if (clr) begin
         prot_ff <= 1'b0;
         ver_ff <= 16'h0000;
         ctrl_ff <= rmv_pkg::CTRL_RST;
         vbase_ff <= rmv_pkg::VBASE_RST;
      end else if (ce_i) begin
         if (load_done) begin
            prot_ff <= flash_cfg_i.dbl_err;
            ver_ff <= flash_cfg_i.version;
            ctrl_ff[rmv_pkg::CTRL_RATE_LSB +: 3] <= ~flash_cfg_i.opt;
         end else if (wr_lo & hit_ctrl) begin
            ctrl_ff <= wb_dat_i[7:0];
         end
         if (wr_lo & hit_vbase) begin
            vbase_ff <= wb_dat_i[7:0];
         end
      end
   end

   // reset cause survives the internal reset so the core fetches its vector
   always_ff @(posedge clock_i) begin
      if (!rst_b_i) begin
         srst_ff <= 1'b0;
         cause_ff <= rmv_pkg::VEC_RESET;
      end else if (ce_i) begin
         srst_ff <= nxt_srst;
         if (nxt_srst) begin
            cause_ff <= cause_vec(fatal_src, clk_src);
         end
      end
   end

   // pin reset, or internal reset with clock enable high, kills a running flash command one clock later
   always_ff @(posedge clock_i) begin
      if (ce_i || !rst_b_i) begin
         abort_ff <= in_rst & flash_busy_i;
      end
   end

   // interrupt request, vector and wake-up
   always_ff @(posedge clock_i) begin
      if (clr) begin
         irq_ff <= 1'b0;
         ivec_ff <= {rmv_pkg::VBASE_RST, rmv_pkg::OFF_LVI};
         wake_ff <= 1'b0;
      end else if (ce_i) begin
         irq_ff <= nxt_irq;
         ivec_ff <= {vbase_ff, irq_off};
         wake_ff <= nxt_wake;
      end
   end

   // wishbone slave: one wait state, unmapped reads zero, writes ignored
   always_ff @(posedge clock_i) begin
      if (!rst_b_i) begin
         ack_ff <= 1'b0;
         dat_ff <= 32'h00000000;
      end else if (ce_i) begin
         ack_ff <= req;
         if (req) begin
            dat_ff <= rd_data;
         end
      end
   end

   assign wb_ack_o = ack_ff;
   assign wb_dat_o = dat_ff;
   assign sys_rst_req_o = srst_ff;
   assign reset_vector_o = cause_ff;
   assign cpu_hold_o = hold_ff;
   assign flash_abort_o = abort_ff;
   assign flash_protect_o = prot_ff;
   assign debug_mode_o = dbg_ff;
   assign irq_req_o = irq_ff;
   assign irq_vector_o = ivec_ff;
   assign wake_o = wake_ff;

   default clocking cb @(posedge clock_i);
   endclocking
   default disable iff (!rst_b_i);

   a_ident_high_read: assert property (
      ack_ff && !wb_we_i && hit_idh |->
      dat_ff[7:0] == rmv_pkg::ID_VALUE[15:8])
      else $error("identity high byte wrong");
   a_ident_low_write: assert property (
      ack_ff && hit_idl |-> dat_ff == 32'h00000052)
      else $error("identity low byte wrong");
   a_ident_field_split: assert property (
      ack_ff && !wb_we_i && hit_idh |->
      dat_ff[7:4] == rmv_pkg::ID_MAJOR_FAM &&
      dat_ff[3:0] == rmv_pkg::ID_MINOR_FAM[5:2])
      else $error("identity field layout wrong");
   a_mode_pin_latch: assert property (
      ce_i && !srst_ff && release_edge |=> mode_ff == $past(sync2_ff))
      else $error("mode not latched at reset release");
   a_mode_one_way: assert property (
      ce_i && !srst_ff && mode_ff && !release_edge |=> mode_ff)
      else $error("mode left normal without reset");
   a_debug_in_special: assert property (
      !release_edge |-> debug_mode_o == (mode_ff == rmv_pkg::MODE_SPECIAL))
      else $error("debug state not matching mode");
   a_clkmon_vector: assert property (
      ce_i && running && !srst_ff && !fatal_src && rst_src_i.clkmon &&
      osc_enable |=> srst_ff && reset_vector_o == 16'hFFFC)
      else $error("clock monitor reset vector wrong");
   a_wdog_gated: assert property (
      ce_i && !fatal_src && !clk_src && watchdog_rate_field == 3'h0
      |=> !srst_ff)
      else $error("watchdog reset while disabled");
   a_fatal_vector: assert property (
      ce_i && running && !srst_ff && fatal_src |=>
      srst_ff ##1 reset_vector_o == 16'hFFFE && hold_ff)
      else $error("fatal reset vector wrong");
   a_spi_wins: assert property (
      ce_i && !srst_ff && running && en_spi && !i_bit_i |=>
      irq_req_o && irq_vector_o[7:0] == 8'hD8)
      else $error("serial interrupt not first");
   a_lock_no_wake: assert property (
      ce_i && !srst_ff && !en_spi && !en_lvi |=> !wake_o)
      else $error("lock interrupt woke the device");
   a_lvi_wake: assert property (
      ce_i && !srst_ff && running && wait_i && en_lvi && !i_bit_i
      |=> wake_o && ($past(en_spi) || $past(en_lock) ||
      irq_vector_o[7:0] == 8'h8A))
      else $error("low voltage wake or vector wrong");
   a_hold_until_load: assert property (
      srst_ff && ce_i |=> hold_ff [*2])
      else $error("core released before configuration load");
   a_regs_back_reset: assert property (
      srst_ff && ce_i |=> vbase_ff == 8'hFF && ctrl_ff == 8'h01)
      else $error("registers not returned to reset state");
   a_protect_on_err: assert property (
      ce_i && !srst_ff && load_done && flash_cfg_i.dbl_err |=> prot_ff)
      else $error("protection not set after double error");
   a_abort_in_reset: assert property (
      ce_i && srst_ff && flash_busy_i |=> flash_abort_o)
      else $error("flash command not aborted");

   c_internal_reset: cover property (running && nxt_srst && ce_i);
   c_config_loaded: cover property (load_done && ce_i);
   c_irq_spi_lock: cover property (en_spi && en_lock && irq_req_o);
   c_mode_switch: cover property (!mode_ff && wr_lo && hit_mode);

endmodule // rmv_top

// ---- dv/rmv_far_model.sv ----
// far side model: flash configuration source and the core fetching vectors
// assumes the unit's clock and reset, and a delay set by the bench
`timescale 1ns/100ps
module rmv_far_model (
   input wire logic clock_i,
   input wire logic rst_b_i,
   input wire logic cpu_hold_i,
   input wire logic [15:0] reset_vector_i,
   input wire logic dbl_err_i,
   input wire logic [2:0] opt_i,
   input wire logic [3:0] dly_i,
   output rmv_pkg::rmv_flash_cfg_s flash_cfg_o,
   output logic [15:0] fetch_vec_o
);
   // version word value is arbitrary
   localparam logic [15:0] VERSION = 16'h0A51;
   logic [3:0] cnt_ff;
   logic hold_q_ff;
   wire logic load_end = cpu_hold_i && (cnt_ff >= dly_i);
   // load runs a while before done is offered, prompt or slow by dly_i
   always_ff @(posedge clock_i) begin
      if (!rst_b_i || !cpu_hold_i) begin
         cnt_ff <= 4'h0;
      end else if (!load_end) begin
         cnt_ff <= cnt_ff + 4'h1;
      end
   end
   // the core fetches the reset vector once it is let go
   always_ff @(posedge clock_i) begin
      hold_q_ff <= cpu_hold_i;
      if (hold_q_ff && !cpu_hold_i) begin
         fetch_vec_o <= reset_vector_i;
      end
   end
   // outside a load the config lines carry no stale data
   assign flash_cfg_o = load_end ? {1'b1, dbl_err_i, opt_i, VERSION} :
      {1'b0, ~dbl_err_i, ~opt_i, ~VERSION};
endmodule // rmv_far_model

// ---- dv/tb.sv ----
// self-checking bench for the reset, mode and vector unit
// assumes the unit's wishbone timing and the far side model
`timescale 1ns/100ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin errors++; \
   $display("mismatch %0t got %h exp %h", $time, g, e); end end
module tb;
   logic clock_i = 1'b0, rst_b_i = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
   logic [9:0] adr = 10'h000;
   logic [31:0] dat = 32'h0, rd;
   logic pin = 1'b1, busy = 1'b0, i_bit = 1'b0, wt = 1'b0, dbl = 1'b0;
   logic [2:0] opt = 3'h0;
   logic ce = 1'b1;
   logic [3:0] dly = 4'h2;
   rmv_pkg::rmv_rst_src_s src = '0;
   rmv_pkg::rmv_irq_src_s irq = '0;
   rmv_pkg::rmv_flash_cfg_s cfg;
   logic ack, sreq, hold, abrt, prot, dbg, ireq, wake;
   logic [31:0] dout;
   logic [15:0] rvec, ivec, fvec;
   int errors = 0, tests_run = 0, cycles = 0;
   always #25 clock_i = ~clock_i;
   rmv_top rmv_top_inst (.clock_i(clock_i), .rst_b_i(rst_b_i), .ce_i(ce),
      .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
      .wb_sel_i(4'h1), .wb_dat_i(dat), .wb_ack_o(ack), .wb_dat_o(dout),
      .mode_select_pin_state_i(pin), .rst_src_i(src), .flash_cfg_i(cfg),
      .flash_busy_i(busy), .irq_src_i(irq), .i_bit_i(i_bit), .wait_i(wt),
      .sys_rst_req_o(sreq), .reset_vector_o(rvec), .cpu_hold_o(hold),
      .flash_abort_o(abrt), .flash_protect_o(prot), .debug_mode_o(dbg),
      .irq_req_o(ireq), .irq_vector_o(ivec), .wake_o(wake));
   rmv_far_model rmv_far_model_inst (.clock_i(clock_i), .rst_b_i(rst_b_i),
      .cpu_hold_i(hold), .reset_vector_i(rvec), .dbl_err_i(dbl),
      .opt_i(opt), .dly_i(dly), .flash_cfg_o(cfg), .fetch_vec_o(fvec));
   task print_verdict();
      if (errors == 0 && tests_run > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   always @(posedge clock_i) begin
      cycles++;
      if (cycles == 5000) begin
         errors++;
         print_verdict();
      end
   end
   task wb(input logic w, input logic [7:0] idx, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clock_i);
      cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= {idx, 2'b00}; dat <= d;
      do begin
         @(posedge clock_i);
         n++;
      end while (ack !== 1'b1 && n < 20);
      rd = dout;
      cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
      if (n >= 20) `CHK(ack, 1'b1)
   endtask
   task wait_run();
      int n;
      n = 0;
      do begin
         @(posedge clock_i);
         n++;
      end while (hold !== 1'b0 && n < 40);
      `CHK(hold, 1'b0)
      // the core fetches its vector one edge after release
      @(posedge clock_i);
   endtask
   task do_reset(input logic p);
      @(posedge clock_i);
      rst_b_i <= 1'b0; pin <= p;
      repeat (3) @(posedge clock_i);
      `CHK(hold, 1'b1)
      `CHK(rvec, rmv_pkg::VEC_RESET)
      rst_b_i <= 1'b1;
      wait_run();
      `CHK(fvec, rmv_pkg::VEC_RESET)
      `CHK(dbg, ~p)
   endtask
   // raise one reset source, expect a pulse carrying vector v when on
   task fire(input rmv_pkg::rmv_rst_src_s s, input logic on,
      input logic [15:0] v);
      logic seen;
      seen = 1'b0;
      @(posedge clock_i);
      src <= s;
      repeat (4) begin
         @(posedge clock_i);
         if (sreq === 1'b1 && !seen) begin
            seen = 1'b1;
            `CHK(rvec, v)
         end
      end
      src <= '0;
      `CHK(seen, on)
      if (on) begin
         wait_run();
         `CHK(fvec, v)
      end
   endtask
   task irq_chk(input logic [3:0] s, input logic r, input logic [7:0] off,
      input logic wk);
      @(posedge clock_i);
      irq <= s;
      repeat (3) @(posedge clock_i);
      `CHK(ireq, r)
      if (r) `CHK(ivec, {8'h12, off})
      `CHK(wake, wk)
   endtask
   initial begin
      dbl = 1'b1;
      do_reset(1'b0);
      `CHK(prot, 1'b1)
      wb(1'b0, rmv_pkg::IDX_MODE, 32'h0);
      `CHK(rd[0], rmv_pkg::MODE_SPECIAL)
      `CHK(dbg, 1'b1)
      wb(1'b1, rmv_pkg::IDX_MODE, 32'h1);
      wb(1'b0, rmv_pkg::IDX_MODE, 32'h0);
      `CHK(rd[0], rmv_pkg::MODE_NORMAL)
      `CHK(dbg, 1'b0)
      dbl <= 1'b0;
      dly <= 4'h9;
      do_reset(1'b1);
      `CHK(prot, 1'b0)
      wb(1'b1, rmv_pkg::IDX_MODE, 32'h0);
      wb(1'b0, rmv_pkg::IDX_MODE, 32'h0);
      `CHK(rd[0], rmv_pkg::MODE_NORMAL)
      wb(1'b1, rmv_pkg::IDX_IDENT_HI, 32'h0);
      wb(1'b1, rmv_pkg::IDX_IDENT_LO, 32'hFF);
      wb(1'b0, rmv_pkg::IDX_IDENT_HI, 32'h0);
      `CHK(rd, {24'h0, rmv_pkg::ID_VALUE[15:8]})
      `CHK(rd[7:4], rmv_pkg::ID_MAJOR_FAM)
      wb(1'b0, rmv_pkg::IDX_IDENT_LO, 32'h0);
      `CHK(rd, {24'h0, rmv_pkg::ID_VALUE[7:0]})
      `CHK(rd[3:0], rmv_pkg::ID_MINOR_REV)
      wb(1'b0, rmv_pkg::IDX_VER, 32'h0);
      `CHK(rd[15:0], 16'h0A51)
      wb(1'b0, rmv_pkg::IDX_VBASE, 32'h0);
      `CHK(rd[7:0], rmv_pkg::VBASE_RST)
      wb(1'b0, rmv_pkg::IDX_CTRL, 32'h0);
      `CHK(rd[7:0], {4'h0, ~opt, 1'b1})
      wb(1'b1, 8'h10, 32'hFF);
      wb(1'b0, 8'h10, 32'h0);
      `CHK(rd, 32'h0)
      fire(6'b000001, 1'b1, rmv_pkg::VEC_WDOG);
      fire(6'b001000, 1'b1, rmv_pkg::VEC_RESET);
      fire(6'b000010, 1'b1, rmv_pkg::VEC_CLKMON);
      busy <= 1'b1;
      fire(6'b000100, 1'b1, rmv_pkg::VEC_RESET);
      busy <= 1'b0;
      fire(6'b100000, 1'b1, rmv_pkg::VEC_RESET);
      wb(1'b1, rmv_pkg::IDX_CTRL, 32'h0);
      fire(6'b000010, 1'b0, 16'h0);
      fire(6'b000001, 1'b0, 16'h0);
      fire(6'b010000, 1'b1, rmv_pkg::VEC_RESET);
      wb(1'b1, rmv_pkg::IDX_VBASE, 32'h12);
      wb(1'b1, rmv_pkg::IDX_CTRL, 32'hF1);
      wt <= 1'b1;
      irq_chk(4'b0001, 1'b1, rmv_pkg::OFF_LVI, 1'b1);
      irq_chk(4'b0010, 1'b1, rmv_pkg::OFF_LOCK, 1'b0);
      irq_chk(4'b0111, 1'b1, rmv_pkg::OFF_SPI, 1'b1);
      irq_chk(4'b1011, 1'b1, rmv_pkg::OFF_SPI, 1'b1);
      wt <= 1'b0;
      irq_chk(4'b0001, 1'b1, rmv_pkg::OFF_LVI, 1'b0);
      // clock enable low: request, vector and wake stay frozen
      ce <= 1'b0;
      irq_chk(4'b1000, 1'b1, rmv_pkg::OFF_LVI, 1'b0);
      ce <= 1'b1;
      i_bit <= 1'b1;
      irq_chk(4'b1111, 1'b0, 8'h00, 1'b0);
      i_bit <= 1'b0;
      wb(1'b1, rmv_pkg::IDX_CTRL, 32'h01);
      irq_chk(4'b1111, 1'b0, 8'h00, 1'b0);
      busy <= 1'b1;
      @(posedge clock_i);
      rst_b_i <= 1'b0;
      repeat (3) @(posedge clock_i);
      `CHK(abrt, 1'b1)
      `CHK(ireq, 1'b0)
      busy <= 1'b0;
      rst_b_i <= 1'b1;
      wait_run();
      wb(1'b0, rmv_pkg::IDX_VBASE, 32'h0);
      `CHK(rd[7:0], rmv_pkg::VBASE_RST)
      print_verdict();
   end
endmodule // tb
